// File: design/pwm_unit_pkg.sv
// Functional notes
// - Up to three generators, each driving one high and one low output.
// - A master time base restarts every generator so all outputs stay aligned.
// - Enabled and asserted fault or current-limit input forces affected outputs off.
// - Every output pair has its own fault and current-limit input.
// - Each generator pulses an ADC trigger at a programmable count in its period.
// - Special event trigger to the ADC compares against either master time base.
// - External sync input, when enabled, restarts the master time base.
// - Sync output pin pulses at every restart of the MPER master time base, not at SPER time base wraps.
// - Each output pair has its own period and duty cycle.
// - Period and duty changes load per generator at its own period start; phase is taken at each master restart.
// - Center-aligned mode counts up and down, doubling the output period relative to the period value.
// - Edge-aligned mode counts up only, one count per prescaled tick.
// - A per-generator option swaps the high and low outputs.
// - Chop mode gates the outputs with a free-running chopping signal.
// - The time-base clock passes a selectable power-of-two prescaler.
// - Leading-edge blanking masks fault and current-limit after selected edges.
// - Safety fault is latched from reset; cleared by software before running.
package pwm_unit_pkg;
  localparam int ADDR_W = 8;
  localparam int MAX_GEN = 3;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MPER = 8'h01;
  localparam logic [7:0] ADDR_SPER = 8'h02;
  localparam logic [7:0] ADDR_SEVT = 8'h03;
  localparam logic [7:0] ADDR_CHOP = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h05;
  localparam logic [7:0] ADDR_ICLR = 8'h06;
  localparam logic [7:0] ADDR_IEN = 8'h07;
  localparam logic [3:0] F_CON = 4'h0;
  localparam logic [3:0] F_PER = 4'h1;
  localparam logic [3:0] F_DUTY = 4'h2;
  localparam logic [3:0] F_PHASE = 4'h3;
  localparam logic [3:0] F_DTIME = 4'h4;
  localparam logic [3:0] F_TRIG = 4'h5;
  localparam logic [3:0] F_LEB = 4'h6;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CENTER = 1;
  localparam int CTRL_PS_LSB = 2;
  localparam int CTRL_SYNCI_EN = 5;
  localparam int CTRL_SEV_SEL = 6;
  localparam int CON_OUT_EN = 0;
  localparam int CON_SWAP = 1;
  localparam int CON_FLT_EN = 2;
  localparam int CON_CL_EN = 3;
  localparam int CON_CHOP_EN = 4;
  localparam int CON_FLT_LEB = 5;
  localparam int CON_CL_LEB = 6;
  localparam int CON_LEB_LSB = 8;
  localparam int ST_FLT_LSB = 0;
  localparam int ST_CL_LSB = 3;
  localparam int ST_SEVT = 6;
  localparam int ST_SYNCI = 7;
  localparam int ST_SAFETY = 8;
  localparam int STAT_W = 9;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_PER = 16'h00ff;
  localparam logic [15:0] RST_CHOP = 16'h000f;
  localparam logic [15:0] RST_ZERO = 16'h0000;
endpackage

// File: design/pwm_pair_gen.sv
`timescale 1ns/1ps
module pwm_pair_gen
  import pwm_unit_pkg::*;
#(
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Time base
  input wire logic tick,
  input wire logic restart,
  input wire logic center,
  // Control
  input wire logic enable,
  input wire logic swap,
  input wire logic flt_en,
  input wire logic cl_en,
  input wire logic chop_en,
  input wire logic chop_gate,
  input wire logic flt_leb_en,
  input wire logic cl_leb_en,
  input wire logic [3:0] leb_edge_en,
  input wire logic kill,
  // Timing values
  input wire logic [DW-1:0] per_in,
  input wire logic [DW-1:0] duty_in,
  input wire logic [DW-1:0] phase_in,
  input wire logic [DW-1:0] dtime_in,
  input wire logic [DW-1:0] trig_in,
  input wire logic [DW-1:0] leb_in,
  // Protection inputs
  input wire logic fault_in,
  input wire logic climit_in,
  // Outputs
  output logic pwm_high_side_out,
  output logic pwm_low_side_out,
  output logic adc_trig,
  output logic fault_evt,
  output logic climit_evt
);
  logic [DW-1:0] cnt_r, per_r, duty_r, dt_cnt_r, leb_cnt_r;
  logic up_r, raw_last_r, hi_r, lo_r, hi_d_r, lo_d_r;
  logic raw, load, edge_hit, flt_det, cl_det, gate, h_pre, l_pre;

  ////////////////////////////////////////////////////////////////////////////
  // Period counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      up_r <= 1'b1;
    end else if (ce) begin
      if (restart) begin
        cnt_r <= phase_in;
        up_r <= 1'b1;
      end else if (tick) begin
        if (!center) begin
          cnt_r <= (cnt_r >= per_r) ? '0 : cnt_r + 1'b1;
        end else if (up_r) begin
          if (cnt_r >= per_r) begin
            up_r <= 1'b0;
            cnt_r <= (cnt_r == '0) ? '0 : cnt_r - 1'b1;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end else if (cnt_r == '0) begin
          up_r <= 1'b1;
          cnt_r <= cnt_r + 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow period and duty
  assign load = !enable || (tick && cnt_r == '0);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      per_r <= DW'(RST_PER);
      duty_r <= '0;
    end else if (ce && load) begin
      per_r <= per_in;
      duty_r <= duty_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead time
  assign raw = enable && (cnt_r < duty_r);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      raw_last_r <= 1'b0;
      dt_cnt_r <= '0;
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end else if (ce) begin
      raw_last_r <= raw;
      if (raw != raw_last_r) begin
        hi_r <= 1'b0;
        lo_r <= 1'b0;
        dt_cnt_r <= dtime_in;
      end else if (dt_cnt_r != '0) begin
        dt_cnt_r <= dt_cnt_r - 1'b1;
      end else begin
        hi_r <= raw;
        lo_r <= enable && !raw;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Leading-edge blanking
  assign edge_hit = (leb_edge_en[0] && hi_r && !hi_d_r) ||
                    (leb_edge_en[1] && !hi_r && hi_d_r) ||
                    (leb_edge_en[2] && lo_r && !lo_d_r) ||
                    (leb_edge_en[3] && !lo_r && lo_d_r);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_d_r <= 1'b0;
      lo_d_r <= 1'b0;
      leb_cnt_r <= '0;
    end else if (ce) begin
      hi_d_r <= hi_r;
      lo_d_r <= lo_r;
      if (edge_hit) begin
        leb_cnt_r <= leb_in;
      end else if (leb_cnt_r != '0) begin
        leb_cnt_r <= leb_cnt_r - 1'b1;
      end
    end
  end

  assign flt_det = flt_en && fault_in && !(leb_cnt_r != '0 && flt_leb_en);
  assign cl_det = cl_en && climit_in && !(leb_cnt_r != '0 && cl_leb_en);

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  assign h_pre = swap ? lo_r : hi_r;
  assign l_pre = swap ? hi_r : lo_r;
  assign gate = enable && !kill && !flt_det && !cl_det &&
                (!chop_en || chop_gate);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_high_side_out <= 1'b0;
      pwm_low_side_out <= 1'b0;
      adc_trig <= 1'b0;
      fault_evt <= 1'b0;
      climit_evt <= 1'b0;
    end else if (ce) begin
      pwm_high_side_out <= gate && h_pre;
      pwm_low_side_out <= gate && l_pre;
      adc_trig <= enable && tick && (cnt_r == trig_in);
      fault_evt <= flt_det;
      climit_evt <= cl_det;
    end
  end
endmodule

// File: design/high_speed_pwm_unit.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module high_speed_pwm_unit
  import pwm_unit_pkg::*;
#(
  parameter int NGEN = 3,
  parameter int DW = 16
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata,
  // Power stage
  output logic [NGEN-1:0] pwm_high_side_out,
  output logic [NGEN-1:0] pwm_low_side_out,
  input wire logic [NGEN-1:0] fault_in,
  input wire logic [NGEN-1:0] climit_in,
  input wire logic safety_fault_input,
  // ADC triggers
  output logic [NGEN-1:0] adc_trigger,
  output logic adc_special_trigger,
  // External sync
  input wire logic ext_sync_in,
  output logic ext_sync_out,
  // Interrupt
  output logic irq
);
  initial begin
    if (NGEN < 1 || NGEN > MAX_GEN) $error("NGEN must be 1 to 3");
    if (DW < 9 || DW > 16) $error("DW must be 9 to 16");
  end

  logic [DW-1:0] ctrl_r, mper_r, sper_r, sevt_r, chop_r;
  logic [DW-1:0] mcnt_r, scnt_r, chop_cnt_r;
  logic [STAT_W-1:0] stat_r, ien_r, stat_set, stat_clr, stat_view;
  logic [DW-1:0] con_r [NGEN];
  logic [DW-1:0] per_r [NGEN];
  logic [DW-1:0] duty_r [NGEN];
  logic [DW-1:0] phase_r [NGEN];
  logic [DW-1:0] dtime_r [NGEN];
  logic [DW-1:0] trig_r [NGEN];
  logic [DW-1:0] leb_r [NGEN];
  logic [NGEN-1:0] fault_evt, climit_evt;
  logic [6:0] ps_cnt_r, ps_max;
  logic tick, run, m_wrap, sync_edge, master_sync, sync_last_r, chop_sig_r;
  logic safe_lat_r;
  logic [DW-1:0] sev_base, gen_rd;
  logic [3:0] fsel;
  logic [3:0] gidx;

  ////////////////////////////////////////////////////////////////////////////
  // Global register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= DW'(RST_CTRL);
      mper_r <= DW'(RST_PER);
      sper_r <= DW'(RST_PER);
      sevt_r <= DW'(RST_ZERO);
      chop_r <= DW'(RST_CHOP);
      ien_r <= '0;
    end else if (ce && wr) begin
      unique case (addr)
        ADDR_CTRL: ctrl_r <= wdata;
        ADDR_MPER: mper_r <= wdata;
        ADDR_SPER: sper_r <= wdata;
        ADDR_SEVT: sevt_r <= wdata;
        ADDR_CHOP: chop_r <= wdata;
        ADDR_IEN: ien_r <= wdata[STAT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-generator registers and generators
  assign fsel = addr[3:0];
  assign gidx = addr[7:4];

  generate
    for (genvar g = 0; g < NGEN; g++) begin : gen_pair
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          con_r[g] <= DW'(RST_ZERO);
          per_r[g] <= DW'(RST_PER);
          duty_r[g] <= DW'(RST_ZERO);
          phase_r[g] <= DW'(RST_ZERO);
          dtime_r[g] <= DW'(RST_ZERO);
          trig_r[g] <= DW'(RST_ZERO);
          leb_r[g] <= DW'(RST_ZERO);
        end else if (ce && wr && gidx == 4'(g + 1)) begin
          unique case (fsel)
            F_CON: con_r[g] <= wdata;
            F_PER: per_r[g] <= wdata;
            F_DUTY: duty_r[g] <= wdata;
            F_PHASE: phase_r[g] <= wdata;
            F_DTIME: dtime_r[g] <= wdata;
            F_TRIG: trig_r[g] <= wdata;
            F_LEB: leb_r[g] <= wdata;
            default: ;
          endcase
        end
      end

      pwm_pair_gen #(
        .DW(DW)
      ) u_gen (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .restart(master_sync),
        .center(ctrl_r[CTRL_CENTER]),
        .enable(run && con_r[g][CON_OUT_EN]),
        .swap(con_r[g][CON_SWAP]),
        .flt_en(con_r[g][CON_FLT_EN]),
        .cl_en(con_r[g][CON_CL_EN]),
        .chop_en(con_r[g][CON_CHOP_EN]),
        .chop_gate(chop_sig_r),
        .flt_leb_en(con_r[g][CON_FLT_LEB]),
        .cl_leb_en(con_r[g][CON_CL_LEB]),
        .leb_edge_en(con_r[g][CON_LEB_LSB+3:CON_LEB_LSB]),
        .kill(safe_lat_r),
        .per_in(per_r[g]),
        .duty_in(duty_r[g]),
        .phase_in(phase_r[g]),
        .dtime_in(dtime_r[g]),
        .trig_in(trig_r[g]),
        .leb_in(leb_r[g]),
        .fault_in(fault_in[g]),
        .climit_in(climit_in[g]),
        .pwm_high_side_out(pwm_high_side_out[g]),
        .pwm_low_side_out(pwm_low_side_out[g]),
        .adc_trig(adc_trigger[g]),
        .fault_evt(fault_evt[g]),
        .climit_evt(climit_evt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  assign ps_max = 7'((8'h01 << ctrl_r[CTRL_PS_LSB+2:CTRL_PS_LSB]) - 8'h01);
  assign tick = ctrl_r[CTRL_EN] && (ps_cnt_r >= ps_max);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ps_cnt_r <= '0;
    end else if (ce) begin
      if (!ctrl_r[CTRL_EN] || tick) begin
        ps_cnt_r <= '0;
      end else begin
        ps_cnt_r <= ps_cnt_r + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master time bases and sync
  assign run = ctrl_r[CTRL_EN] && !safe_lat_r;
  assign m_wrap = tick && (mcnt_r >= mper_r);
  assign sync_edge = ctrl_r[CTRL_SYNCI_EN] && ext_sync_in && !sync_last_r;
  assign master_sync = m_wrap || sync_edge;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_last_r <= 1'b0;
    end else if (ce) begin
      sync_last_r <= ext_sync_in;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mcnt_r <= '0;
    end else if (ce) begin
      if (sync_edge || m_wrap) begin
        mcnt_r <= '0;
      end else if (tick) begin
        mcnt_r <= mcnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scnt_r <= '0;
    end else if (ce && tick) begin
      scnt_r <= (scnt_r >= sper_r) ? '0 : scnt_r + 1'b1;
    end
  end

  assign sev_base = ctrl_r[CTRL_SEV_SEL] ? scnt_r : mcnt_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_sync_out <= 1'b0;
      adc_special_trigger <= 1'b0;
    end else if (ce) begin
      ext_sync_out <= master_sync;
      adc_special_trigger <= run && tick && (sev_base == sevt_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chopping clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chop_cnt_r <= '0;
      chop_sig_r <= 1'b0;
    end else if (ce) begin
      if (chop_cnt_r >= chop_r) begin
        chop_cnt_r <= '0;
        chop_sig_r <= !chop_sig_r;
      end else begin
        chop_cnt_r <= chop_cnt_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safety fault latch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      safe_lat_r <= 1'b1;
    end else if (ce) begin
      if (safety_fault_input) begin
        safe_lat_r <= 1'b1;
      end else if (wr && addr == ADDR_ICLR && wdata[ST_SAFETY]) begin
        safe_lat_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status
  always_comb begin
    stat_set = '0;
    for (int i = 0; i < NGEN; i++) begin
      stat_set[ST_FLT_LSB+i] = fault_evt[i];
      stat_set[ST_CL_LSB+i] = climit_evt[i];
    end
    stat_set[ST_SEVT] = adc_special_trigger;
    stat_set[ST_SYNCI] = sync_edge;
    stat_set[ST_SAFETY] = 1'b0;
  end

  assign stat_clr = (wr && addr == ADDR_ICLR) ? wdata[STAT_W-1:0] : '0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else if (ce) begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  always_comb begin
    stat_view = stat_r;
    stat_view[ST_SAFETY] = safe_lat_r;
  end

  assign irq = |(stat_view & ien_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    gen_rd = '0;
    for (int i = 0; i < NGEN; i++) begin
      if (gidx == 4'(i + 1)) begin
        unique case (fsel)
          F_CON: gen_rd = con_r[i];
          F_PER: gen_rd = per_r[i];
          F_DUTY: gen_rd = duty_r[i];
          F_PHASE: gen_rd = phase_r[i];
          F_DTIME: gen_rd = dtime_r[i];
          F_TRIG: gen_rd = trig_r[i];
          F_LEB: gen_rd = leb_r[i];
          default: gen_rd = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce && rd) begin
      unique case (addr)
        ADDR_CTRL: rdata <= ctrl_r;
        ADDR_MPER: rdata <= mper_r;
        ADDR_SPER: rdata <= sper_r;
        ADDR_SEVT: rdata <= sevt_r;
        ADDR_CHOP: rdata <= chop_r;
        ADDR_STAT: rdata <= DW'(stat_view);
        ADDR_IEN: rdata <= DW'(ien_r);
        default: rdata <= gen_rd;
      endcase
    end
  end
endmodule

// File: tb/pwm_unit_props.sv
`timescale 1ns/1ps
module pwm_unit_props
  import pwm_unit_pkg::*;
#(
  parameter int NGEN = 3,
  parameter int DW = 16
) (
  // Clock and register port
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  // Pins
  input wire logic [NGEN-1:0] pwm_high_side_out,
  input wire logic [NGEN-1:0] pwm_low_side_out,
  input wire logic [NGEN-1:0] fault_in,
  input wire logic [NGEN-1:0] climit_in,
  input wire logic safety_fault_input,
  input wire logic [NGEN-1:0] adc_trigger,
  input wire logic adc_special_trigger,
  input wire logic ext_sync_out,
  input wire logic irq
);
  logic ctrl_en_r;
  logic [STAT_W-1:0] ien_r;
  logic [3:0] con0_r;
  logic [3:0] con1_r;
  logic [NGEN-1:0] on_w;
  assign on_w = pwm_high_side_out | pwm_low_side_out;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the control bits written by software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_en_r <= 1'b0;
      ien_r <= '0;
      con0_r <= 4'h0;
      con1_r <= 4'h0;
    end else if (ce && wr) begin
      case (addr)
        ADDR_CTRL: ctrl_en_r <= wdata[CTRL_EN];
        ADDR_IEN: ien_r <= wdata[STAT_W-1:0];
        8'h10: con0_r <= wdata[3:0];
        8'h20: con1_r <= wdata[3:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  no_overlap_a:
    assert property ((pwm_high_side_out & pwm_low_side_out) == '0)
    else $error("High and low side on together");
  reset_quiet_a:
    assert property ($fell(rst) |-> on_w == '0 && adc_trigger == '0 && !irq)
    else $error("Outputs active right after reset");
  safety_off_a:
    assert property (safety_fault_input [*3] |-> on_w == '0)
    else $error("Outputs run during safety fault");
  unit_idle_a:
    assert property ((!ctrl_en_r) [*3] |-> on_w == '0 && adc_trigger == '0 && !adc_special_trigger)
    else $error("Activity while unit disabled");
  gen_off_a:
    assert property ((!con0_r[CON_OUT_EN]) [*3] |-> !on_w[0])
    else $error("Disabled generator drives outputs");
  sync_out_run_a:
    assert property (ext_sync_out |-> ctrl_en_r || $past(ctrl_en_r))
    else $error("Sync output pulse while time base stopped");
  irq_mask_a:
    assert property (ien_r == '0 |-> !irq)
    else $error("Interrupt with all sources masked");
  fault_off_a:
    assert property ((con0_r[CON_FLT_EN] && fault_in[0]) [*3] |-> !on_w[0])
    else $error("Fault did not force pair off");
  climit_off_a:
    assert property ((con1_r[CON_CL_EN] && climit_in[1]) [*3] |-> !on_w[1])
    else $error("Current limit did not force pair off");
endmodule
bind high_speed_pwm_unit pwm_unit_props #(.NGEN(NGEN), .DW(DW)) u_props (
  .clock, .rst, .ce, .addr, .wdata, .wr, .pwm_high_side_out, .pwm_low_side_out,
  .fault_in, .climit_in, .safety_fault_input, .adc_trigger, .adc_special_trigger,
  .ext_sync_out, .irq
);

// File: tb/pwm_far_side.sv
`timescale 1ns/1ps
module pwm_far_side #(
  parameter int NGEN = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench commands
  input wire logic [NGEN-1:0] fault_req,
  input wire logic [NGEN-1:0] climit_req,
  input wire logic safety_req,
  input wire logic sync_req,
  // Toward the unit
  output logic [NGEN-1:0] fault_in,
  output logic [NGEN-1:0] climit_in,
  output logic safety_fault_input,
  output logic ext_sync_in
);
  logic [1:0] sync_cnt_r;
  // Stage sensors follow their state; sync source pulses two cycles per request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_in <= '0;
      climit_in <= '0;
      safety_fault_input <= 1'b0;
      sync_cnt_r <= 2'h0;
    end else begin
      fault_in <= fault_req;
      climit_in <= climit_req;
      safety_fault_input <= safety_req;
      sync_cnt_r <= sync_req ? 2'h2 : sync_cnt_r - {1'b0, sync_cnt_r != 2'h0};
    end
  end
  assign ext_sync_in = sync_cnt_r != 2'h0;
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import pwm_unit_pkg::*;
;
  localparam int NG = 3;
  logic clock = 1'b0;
  logic rst;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [NG-1:0] hs, ls, trg, flt, clim;
  logic [NG-1:0] flt_req = 3'h0;
  logic [NG-1:0] clim_req = 3'h0;
  logic safety_req = 1'b0;
  logic sync_req = 1'b0;
  logic safety, sync_in, sync_out, spec, irq;
  int error_cnt = 0;
  int num_checks = 0;
  int hc[NG], lc[NG], tc[NG];
  int sc, ec, gap;
  always #25 clock = ~clock;
  high_speed_pwm_unit #(.NGEN(NG), .DW(16)) u_dut (
    .clock, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .pwm_high_side_out(hs),
    .pwm_low_side_out(ls), .fault_in(flt), .climit_in(clim), .safety_fault_input(safety),
    .adc_trigger(trg), .adc_special_trigger(spec), .ext_sync_in(sync_in),
    .ext_sync_out(sync_out), .irq
  );
  pwm_far_side #(.NGEN(NG)) u_far (
    .clock, .rst, .fault_req(flt_req), .climit_req(clim_req), .safety_req, .sync_req,
    .fault_in(flt), .climit_in(clim), .safety_fault_input(safety), .ext_sync_in(sync_in)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata & m, exp);
  endtask
  task automatic measure(input int n);
    hc = '{default: 0};
    lc = '{default: 0};
    tc = '{default: 0};
    sc = 0;
    ec = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      for (int g = 0; g < NG; g++) begin
        hc[g] += int'(hs[g] === 1'b1);
        lc[g] += int'(ls[g] === 1'b1);
        tc[g] += int'(trg[g] === 1'b1);
      end
      sc += int'(sync_out === 1'b1);
      ec += int'(spec === 1'b1);
    end
  endtask
  task automatic setup_gen(input logic [7:0] b, input logic [15:0] duty);
    wreg(b + F_PER, 16'h0009);
    wreg(b + F_DUTY, duty);
    wreg(b + F_DTIME, 16'h0001);
    wreg(b + F_TRIG, 16'h0004);
    wreg(b + F_CON, 16'h0001);
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, safety latch held off and then cleared
  task automatic t_safety;
    check(hs | ls | {2'h0, irq}, 3'h0);
    rchk(ADDR_STAT, 16'hffff, 16'h0100);
    rchk(8'hff, 16'hffff, 16'h0000);
    rchk(ADDR_MPER, 16'hffff, RST_PER);
    wreg(ADDR_MPER, 16'h0009);
    wreg(ADDR_SEVT, 16'h0002);
    setup_gen(8'h10, 16'h0005);
    setup_gen(8'h20, 16'h0003);
    safety_req <= 1'b1;
    wreg(ADDR_CTRL, 16'h0001);
    wreg(ADDR_ICLR, 16'h0100);
    measure(40);
    check(hc[0] + lc[0] + hc[1] + lc[1], 0);
    rchk(ADDR_STAT, 16'h0100, 16'h0100);
    safety_req <= 1'b0;
    repeat (3) @(posedge clock);
    wreg(ADDR_ICLR, 16'h0100);
    rchk(ADDR_STAT, 16'h0100, 16'h0000);
  endtask
  // Two pairs with own duty, triggers and time base pulses
  task automatic t_run(input int h0, input int l0, input int h1, input int l1);
    repeat (30) @(posedge clock);
    measure(100);
    check(hc[0], h0);
    check(lc[0], l0);
    check(hc[1], h1);
    check(lc[1], l1);
    check(hc[2] + lc[2], 0);
    check(tc[0] + tc[1], 20);
    check(sc, 10);
    check(ec, 10);
  endtask
  // Fault on one pair, current limit on the other, with interrupt
  task automatic t_protect;
    wreg(8'h10, 16'h0005);
    wreg(ADDR_IEN, 16'h0001);
    flt_req <= 3'h1;
    repeat (5) @(posedge clock);
    measure(40);
    check(hc[0] + lc[0], 0);
    check(hc[1], 4);
    check(irq, 1'b1);
    wreg(ADDR_ICLR, 16'h0001);
    rchk(ADDR_STAT, 16'h0001, 16'h0001);
    wreg(ADDR_IEN, 16'h0000);
    check(irq, 1'b0);
    flt_req <= 3'h0;
    wreg(8'h20, 16'h0009);
    clim_req <= 3'h2;
    repeat (5) @(posedge clock);
    measure(40);
    check(hc[1] + lc[1], 0);
    check(hc[0], 12);
    rchk(ADDR_STAT, 16'h0039, 16'h0011);
    clim_req <= 3'h0;
    repeat (3) @(posedge clock);
    wreg(ADDR_ICLR, 16'h00ff);
    wreg(ADDR_IEN, 16'h0001);
    check(irq, 1'b0);
    wreg(ADDR_IEN, 16'h0000);
    wreg(8'h10, 16'h0001);
    wreg(8'h20, 16'h0001);
  endtask
  // External sync restarts the time base early
  task automatic t_sync;
    wreg(ADDR_CTRL, 16'h0021);
    gap = 0;
    while (sync_out !== 1'b1 && gap < 50) begin
      @(posedge clock);
      #1;
      gap++;
    end
    repeat (2) @(posedge clock);
    sync_req <= 1'b1;
    @(posedge clock);
    sync_req <= 1'b0;
    #1;
    gap = 3;
    while (sync_out !== 1'b1 && gap < 50) begin
      @(posedge clock);
      #1;
      gap++;
    end
    check(gap < 9, 1'b1);
    rchk(ADDR_STAT, 16'h0080, 16'h0080);
  endtask
  // Chop gating, then center-aligned counting
  task automatic t_mode;
    wreg(ADDR_CHOP, 16'h0009);
    wreg(8'h10, 16'h0011);
    repeat (30) @(posedge clock);
    measure(200);
    check(hc[0] + lc[0], 60);
    wreg(8'h10, 16'h0001);
    wreg(ADDR_MPER, 16'h0011);
    wreg(ADDR_CTRL, 16'h0003);
    repeat (40) @(posedge clock);
    measure(180);
    check(hc[0], 70);
    check(hc[1], 30);
    check(sc, 10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_safety();
    t_run(30, 30, 10, 50);
    wreg(8'h12, 16'h0007);
    wreg(8'h20, 16'h0003);
    t_run(50, 10, 50, 10);
    wreg(8'h12, 16'h0005);
    wreg(8'h20, 16'h0001);
    wreg(ADDR_CTRL, 16'h0005);
    repeat (60) @(posedge clock);
    measure(200);
    check(sc, 10);
    check(tc[0], 10);
    wreg(ADDR_CTRL, 16'h0001);
    t_protect();
    t_sync();
    wreg(ADDR_SPER, 16'h0004);
    wreg(ADDR_CTRL, 16'h0041);
    repeat (20) @(posedge clock);
    measure(100);
    check(ec, 20);
    t_mode();
    stop_test();
  end
  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
endmodule
